// ==== rtl/bpmc_top.sv ====
/*
 * Compare and response control of a pair of bus performance counters,
 * with an AXI4-Lite register slave and a read-to-clear interrupt.
 * Assumes counters, qualifiers and bus address arrive on clk; rst_n is synchronous.
 */
// Register access over AXI4-Lite is this design's own decision.
// Function
// R1: Compare mode 00 ignores the compare register and compares nothing.
// R2: Compare mode 01 sets the count-compare status bit 13 when the counter exceeds the compare value.
// R3: Compare mode 10 loads the counter into the compare register when the counter is greater.
// R4: The max-compare evaluation happens each time the counter increments.
// R5: A greater-than result goes to the status collector, the event pins or both, as selected.
// R6: The compare includes bit 31, and once overflow status is set later compares leave status alone.
// R7: Software should program bit 31 of the compare register to zero in the max modes.
// R8: In address mode counter 0 matches above its compare value and counter 1 at or below it.
// R9: In address mode both address matches are ANDed into a range match qualifying both counters.
// R10: The address compare uses request address bits 38 down to 7.
// R11: Each compare register is 32-bit read-write and resets to all ones.
// R12: The group selection picks bus events, resource events, utilizations, or nothing for 11.
// R13: Each response register controls its counter and shows its overflow and compare status.
// R14: Compare mode 11 is the address range mode and leaves the event status alone.
// R15: Response bits 31 to 26 read as zero and ignore writes.
module bpmc_top (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// AXI4-Lite write channels.
	input wire logic [bpmc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels.
	input wire logic [bpmc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Counters and monitored bus.
	input wire bpmc_pkg::bpmc_cnt_t event_counter [2],
	input wire logic [38:7] bus_req_addr,
	input wire logic [2:0] event_qualifier_hit [2],
	// Results.
	output logic [1:0] event_group [2],
	output logic [1:0] qual_match,
	output logic range_match,
	output logic [1:0] perf_status_collector,
	output logic [1:0] event_output_pins,
	output logic irq
);

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	logic aw_hold_r, w_hold_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r, rdata_r;
	logic [3:0] wstrb_r;
	logic [1:0] bresp_r, rresp_r;

	// A write is done once address and data are both held and no answer waits.
	wire logic aw_fire = s_axi_awvalid && awready_r;
	wire logic w_fire = s_axi_wvalid && wready_r;
	wire logic wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
	wire logic ar_fire = s_axi_arvalid && arready_r;
	wire logic aw_hold_nxt = aw_fire ? 1'b1 : (wr_fire ? 1'b0 : aw_hold_r);
	wire logic w_hold_nxt = w_fire ? 1'b1 : (wr_fire ? 1'b0 : w_hold_r);
	wire logic bvalid_nxt = wr_fire ? 1'b1 : ((bvalid_r && s_axi_bready) ? 1'b0 : bvalid_r);
	wire logic rvalid_nxt = ar_fire ? 1'b1 : ((rvalid_r && s_axi_rready) ? 1'b0 : rvalid_r);

	// Address decode of both directions.
	wire logic wr_map = awaddr_r inside {bpmc_pkg::OFF_RESP0, bpmc_pkg::OFF_CMP0, bpmc_pkg::OFF_RESP1,
		bpmc_pkg::OFF_CMP1, bpmc_pkg::OFF_IRQ_ST, bpmc_pkg::OFF_IRQ_MASK};
	wire logic rd_map = s_axi_araddr inside {bpmc_pkg::OFF_RESP0, bpmc_pkg::OFF_CMP0, bpmc_pkg::OFF_RESP1,
		bpmc_pkg::OFF_CMP1, bpmc_pkg::OFF_IRQ_ST, bpmc_pkg::OFF_IRQ_MASK};
	wire logic irq_rd_clr = ar_fire && (s_axi_araddr == bpmc_pkg::OFF_IRQ_ST);
	wire logic mask_wr = wr_fire && (awaddr_r == bpmc_pkg::OFF_IRQ_MASK);

	// Ready flags are registered so every bus output leaves a flip-flop.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
		end else begin
			aw_hold_r <= aw_hold_nxt;
			w_hold_r <= w_hold_nxt;
			awready_r <= !aw_hold_nxt && !bvalid_nxt;
			wready_r <= !w_hold_nxt && !bvalid_nxt;
			bvalid_r <= bvalid_nxt;
			arready_r <= !rvalid_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	// Payload registers of the bus.
	logic [31:0] rd_word;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			awaddr_r <= 8'h0;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
			bresp_r <= 2'h0;
			rdata_r <= 32'h0;
			rresp_r <= 2'h0;
		end else begin
			if (aw_fire) awaddr_r <= s_axi_awaddr;
			if (w_fire) wdata_r <= s_axi_wdata;
			if (w_fire) wstrb_r <= s_axi_wstrb;
			if (wr_fire) bresp_r <= wr_map ? bpmc_pkg::RESP_OKAY : bpmc_pkg::RESP_SLVERR;
			if (ar_fire) rdata_r <= rd_map ? rd_word : 32'h0;
			if (ar_fire) rresp_r <= rd_map ? bpmc_pkg::RESP_OKAY : bpmc_pkg::RESP_SLVERR;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// ------------------------------------------------------------
	// Counter pair
	// ------------------------------------------------------------
	bpmc_pkg::bpmc_ctrl_t ctrl_r [2];
	logic [31:0] cmp_r [2];
	logic [1:0] gt_evt, load_cmp, addr_hit, cmp_set, ovf_set, ovf_prev_r, sel_qual;
	localparam int IRQ_W_L = bpmc_pkg::IRQ_W;
	logic [IRQ_W_L-1:0] irq_st_r, irq_mask_r;
	logic [1:0] qual_r, coll_r, pins_r;
	logic range_r;
	logic irq_r;

	// Range match needs both bounds to hit in the same cycle.
	wire logic range_hit = addr_hit[0] && addr_hit[1]; // R9

	for (genvar i = 0; i < 2; i++) begin : g_cnt
		wire logic resp_wr = wr_fire && (awaddr_r == bpmc_pkg::resp_off(i));
		wire logic cmp_wr = wr_fire && (awaddr_r == bpmc_pkg::cmp_off(i));
		wire logic [31:0] resp_m = bpmc_pkg::strb_merge(bpmc_pkg::resp_pack(ctrl_r[i]), wdata_r, wstrb_r);
		wire logic clr_byte = wstrb_r[1];

		bpmc_cmp_unit #(
			.IS_CEILING(i == 1)
		) u_cmp (
			.mode(ctrl_r[i].mode),
			.cmp(cmp_r[i]),
			.cnt(event_counter[i]),
			.addr(bus_req_addr), // R10
			.gt_evt(gt_evt[i]),
			.load_cmp(load_cmp[i]),
			.addr_hit(addr_hit[i])
		);

		// Overflow status follows the rising overflow bit; a set overflow status bit blocks compare status.
		assign ovf_set[i] = event_counter[i].value[bpmc_pkg::CNT_OVF_BIT] && !ovf_prev_r[i];
		assign cmp_set[i] = gt_evt[i] && !ctrl_r[i].ovf_st; // R2 R6
		// Group 11 selects no qualifier set at all.
		assign sel_qual[i] = (ctrl_r[i].grp != bpmc_pkg::GRP_RSVD) && event_qualifier_hit[i][ctrl_r[i].grp]; // R12

		// Response register: fields written under strobes, status bits written one to clear.
		// A hardware set in the clearing cycle wins so no event is lost.
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				ctrl_r[i] <= '0;
				ovf_prev_r[i] <= 1'b0;
			end else begin
				ovf_prev_r[i] <= event_counter[i].value[bpmc_pkg::CNT_OVF_BIT];
				if (resp_wr) begin // R13 R15
					ctrl_r[i].grp <= bpmc_pkg::bpmc_grp_t'(resp_m[bpmc_pkg::GRP_LSB +: 2]);
					ctrl_r[i].mode <= bpmc_pkg::bpmc_mode_t'(resp_m[bpmc_pkg::MODE_LSB +: 2]);
					ctrl_r[i].pins_en <= resp_m[bpmc_pkg::PINS_EN_BIT];
					ctrl_r[i].coll_en <= resp_m[bpmc_pkg::COLL_EN_BIT];
				end
				ctrl_r[i].cmp_st <= cmp_set[i] || (ctrl_r[i].cmp_st &&
					!(resp_wr && clr_byte && wdata_r[bpmc_pkg::CMP_ST_BIT])); // R2 R14
				ctrl_r[i].ovf_st <= ovf_set[i] || (ctrl_r[i].ovf_st &&
					!(resp_wr && clr_byte && wdata_r[bpmc_pkg::OVF_ST_BIT])); // R6
			end
		end

		// Compare register: a bus write takes precedence over the tracking load.
		always_ff @(posedge clk) begin
			if (!rst_n) cmp_r[i] <= bpmc_pkg::CMP_RESET; // R11
			else if (cmp_wr) cmp_r[i] <= bpmc_pkg::strb_merge(cmp_r[i], wdata_r, wstrb_r); // R11
			else if (load_cmp[i]) cmp_r[i] <= event_counter[i].value; // R3
		end

		// Qualified match and greater-than reporting, one cycle after the cause.
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				qual_r[i] <= 1'b0;
				coll_r[i] <= 1'b0;
				pins_r[i] <= 1'b0;
			end else begin
				qual_r[i] <= sel_qual[i] && (ctrl_r[i].mode != bpmc_pkg::MODE_ADDR || range_hit); // R9
				coll_r[i] <= cmp_set[i] && ctrl_r[i].coll_en; // R5
				pins_r[i] <= cmp_set[i] && ctrl_r[i].pins_en; // R5
			end
		end

		assign event_group[i] = ctrl_r[i].grp;

		// Checks of the compare behaviour.
		sequence s_max_hit;
			ctrl_r[i].mode == bpmc_pkg::MODE_MAX && event_counter[i].inc
				&& event_counter[i].value > cmp_r[i] && !ctrl_r[i].ovf_st;
		endsequence
		property p_off_quiet;
			@(posedge clk) disable iff (!rst_n)
			ctrl_r[i].mode == bpmc_pkg::MODE_OFF && !cmp_wr |=> $stable(cmp_r[i]) && !coll_r[i] && !pins_r[i];
		endproperty
		a_off_quiet: assert property (p_off_quiet) else $error("disabled compare changed state"); // R1
		property p_max_sets;
			@(posedge clk) disable iff (!rst_n)
			s_max_hit |=> ctrl_r[i].cmp_st;
		endproperty
		a_max_sets: assert property (p_max_sets) else $error("compare status not set"); // R2
		property p_track_load;
			@(posedge clk) disable iff (!rst_n)
			ctrl_r[i].mode == bpmc_pkg::MODE_TRACK && event_counter[i].inc
				&& event_counter[i].value > cmp_r[i] && !cmp_wr |=> cmp_r[i] == $past(event_counter[i].value);
		endproperty
		a_track_load: assert property (p_track_load) else $error("compare value not tracked"); // R3
		property p_no_inc;
			@(posedge clk) disable iff (!rst_n)
			!event_counter[i].inc && !cmp_wr |=> $stable(cmp_r[i]) && !coll_r[i];
		endproperty
		a_no_inc: assert property (p_no_inc) else $error("evaluation without increment"); // R4
		property p_report;
			@(posedge clk) disable iff (!rst_n)
			s_max_hit ##0 ctrl_r[i].coll_en ##0 ctrl_r[i].pins_en |=> coll_r[i] && pins_r[i];
		endproperty
		a_report: assert property (p_report) else $error("greater-than not reported"); // R5
		property p_ovf_blocks;
			@(posedge clk) disable iff (!rst_n)
			ctrl_r[i].ovf_st && !ctrl_r[i].cmp_st && !resp_wr |=> !ctrl_r[i].cmp_st;
		endproperty
		a_ovf_blocks: assert property (p_ovf_blocks) else $error("status changed after overflow"); // R6
		property p_addr_mode;
			@(posedge clk) disable iff (!rst_n)
			ctrl_r[i].mode == bpmc_pkg::MODE_ADDR && ctrl_r[i].cmp_st == 1'b0 |=> !ctrl_r[i].cmp_st;
		endproperty
		a_addr_mode: assert property (p_addr_mode) else $error("address mode touched status"); // R14
		property p_grp_rsvd;
			@(posedge clk) disable iff (!rst_n)
			ctrl_r[i].grp == bpmc_pkg::GRP_RSVD |=> !qual_r[i];
		endproperty
		a_grp_rsvd: assert property (p_grp_rsvd) else $error("reserved group matched"); // R12
	end

	// ------------------------------------------------------------
	// Read mux, range output and interrupt
	// ------------------------------------------------------------
	assign rd_word = (s_axi_araddr == bpmc_pkg::OFF_RESP0) ? bpmc_pkg::resp_pack(ctrl_r[0]) :
		(s_axi_araddr == bpmc_pkg::OFF_CMP0) ? cmp_r[0] :
		(s_axi_araddr == bpmc_pkg::OFF_RESP1) ? bpmc_pkg::resp_pack(ctrl_r[1]) :
		(s_axi_araddr == bpmc_pkg::OFF_CMP1) ? cmp_r[1] :
		(s_axi_araddr == bpmc_pkg::OFF_IRQ_ST) ? {28'h0, irq_st_r} : {28'h0, irq_mask_r}; // R13 R15

	// Status clears on read; an event in the same cycle survives the clear.
	wire logic [IRQ_W_L-1:0] irq_evt = {ovf_set, cmp_set};
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_st_r <= 4'h0;
			irq_mask_r <= 4'h0;
			irq_r <= 1'b0;
			range_r <= 1'b0;
		end else begin
			irq_st_r <= irq_evt | (irq_rd_clr ? 4'h0 : irq_st_r);
			if (mask_wr && wstrb_r[0]) irq_mask_r <= wdata_r[IRQ_W_L-1:0];
			irq_r <= |(irq_st_r & irq_mask_r);
			range_r <= range_hit; // R9
		end
	end

	assign qual_match = qual_r;
	assign range_match = range_r;
	assign perf_status_collector = coll_r;
	assign event_output_pins = pins_r;
	assign irq = irq_r;

	property p_cmp_reset;
		@(posedge clk) !rst_n |=> cmp_r[0] == bpmc_pkg::CMP_RESET && cmp_r[1] == bpmc_pkg::CMP_RESET;
	endproperty
	a_cmp_reset: assert property (p_cmp_reset) else $error("compare register reset wrong"); // R11
	property p_range;
		@(posedge clk) disable iff (!rst_n)
		ctrl_r[0].mode == bpmc_pkg::MODE_ADDR && ctrl_r[1].mode == bpmc_pkg::MODE_ADDR
			&& {1'b0, bus_req_addr} > cmp_r[0] && {1'b0, bus_req_addr} <= cmp_r[1] |=> range_match; // R8 R10
	endproperty
	a_range: assert property (p_range) else $error("range match missed"); // R8
	property p_resv_zero;
		@(posedge clk) disable iff (!rst_n)
		ar_fire && (s_axi_araddr == bpmc_pkg::OFF_RESP0 || s_axi_araddr == bpmc_pkg::OFF_RESP1)
			|=> s_axi_rdata[31:26] == 6'h0;
	endproperty
	a_resv_zero: assert property (p_resv_zero) else $error("reserved bits read nonzero"); // R15

endmodule

// ==== common/bpmc_pkg.sv ====
/*
 * Shared constants and types of the bus performance monitor compare block:
 * register offsets, field positions, reset values, compare modes and carriers.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses in 8 bits.
 */
package bpmc_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_RESP0 = 8'ha0;
	localparam logic [7:0] OFF_CMP0 = 8'ha4;
	localparam logic [7:0] OFF_RESP1 = 8'he0;
	localparam logic [7:0] OFF_CMP1 = 8'he4;
	localparam logic [7:0] OFF_IRQ_ST = 8'hf0;
	localparam logic [7:0] OFF_IRQ_MASK = 8'hf4;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int GRP_LSB = 24;
	localparam int MODE_LSB = 22;
	localparam int PINS_EN_BIT = 15;
	localparam int COLL_EN_BIT = 14;
	localparam int CMP_ST_BIT = 13;
	localparam int OVF_ST_BIT = 12;
	localparam int CNT_OVF_BIT = 31;
	localparam logic [31:0] CMP_RESET = 32'hffffffff;
	localparam int IRQ_W = 4;
	localparam int IRQ_CMP0 = 0;
	localparam int IRQ_OVF0 = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_OFF = 2'h0,
		MODE_MAX = 2'h1,
		MODE_TRACK = 2'h2,
		MODE_ADDR = 2'h3
	} bpmc_mode_t;

	typedef enum logic [1:0] {
		GRP_BUS = 2'h0,
		GRP_RES = 2'h1,
		GRP_UTIL = 2'h2,
		GRP_RSVD = 2'h3
	} bpmc_grp_t;

	typedef struct packed {
		bpmc_grp_t grp;
		bpmc_mode_t mode;
		logic pins_en;
		logic coll_en;
		logic cmp_st;
		logic ovf_st;
	} bpmc_ctrl_t;

	typedef struct packed {
		logic inc;
		logic [31:0] value;
	} bpmc_cnt_t;

	// Byte offsets of the response and compare registers of counter i.
	function automatic logic [7:0] resp_off(input int i);
		resp_off = (i == 0) ? OFF_RESP0 : OFF_RESP1;
	endfunction

	function automatic logic [7:0] cmp_off(input int i);
		cmp_off = (i == 0) ? OFF_CMP0 : OFF_CMP1;
	endfunction

	// Merge a bus write into an old word under the byte strobes.
	function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		for (int b = 0; b < 4; b++) begin
			strb_merge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
		end
	endfunction

	// Software view of a response register; unused bits read as zero.
	function automatic logic [31:0] resp_pack(input bpmc_ctrl_t c);
		resp_pack = 32'h0;
		resp_pack[GRP_LSB +: 2] = c.grp;
		resp_pack[MODE_LSB +: 2] = c.mode;
		resp_pack[PINS_EN_BIT] = c.pins_en;
		resp_pack[COLL_EN_BIT] = c.coll_en;
		resp_pack[CMP_ST_BIT] = c.cmp_st;
		resp_pack[OVF_ST_BIT] = c.ovf_st;
	endfunction

endpackage

// ==== rtl/bpmc_cmp_unit.sv ====
/*
 * Compare unit of one counter: count-versus-compare in the max modes and
 * address-versus-compare in the address range mode.
 * Assumes counter and bus address come from logic on the same clock.
 */
module bpmc_cmp_unit #(
	parameter bit IS_CEILING = 1'b0
) (
	// Configuration.
	input wire bpmc_pkg::bpmc_mode_t mode,
	input wire logic [31:0] cmp,
	// Counter and bus request.
	input wire bpmc_pkg::bpmc_cnt_t cnt,
	input wire logic [31:0] addr,
	// Results.
	output logic gt_evt,
	output logic load_cmp,
	output logic addr_hit
);

	// ------------------------------------------------------------
	// Comparators
	// ------------------------------------------------------------
	// The full 32 bits take part, overflow bit included.
	wire logic cnt_gt = cnt.value > cmp;
	wire logic addr_gt = addr > cmp;

	// Evaluation happens only on an increment; a disabled mode ignores cmp.
	assign gt_evt = cnt.inc && cnt_gt && (mode == bpmc_pkg::MODE_MAX); // R2 R4 R1
	assign load_cmp = cnt.inc && cnt_gt && (mode == bpmc_pkg::MODE_TRACK); // R3 R4 R1
	// The ceiling counter is the inverse of greater-than.
	assign addr_hit = (mode == bpmc_pkg::MODE_ADDR) && (IS_CEILING ? !addr_gt : addr_gt); // R8

endmodule

// ==== sim/bpmc_bus_model.sv ====
/*
 * Behavioural model of the monitored bus side: the pair of event counters.
 * Assumes the bench drives its requests on clk by non-blocking assignment.
 */
module bpmc_bus_model (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Requests from the bench.
	input wire logic [1:0] bump,
	input wire logic [1:0] preset,
	input wire logic [31:0] preset_val,
	// Counters seen by the block.
	output bpmc_pkg::bpmc_cnt_t cnt [2]
);
	timeunit 1ns;
	timeprecision 1ps;

	// A preset loads a value with no increment pulse, like a software preload.
	// It lets the bench move bit 31 without a compare.
	always_ff @(posedge clk) begin
		for (int i = 0; i < 2; i++) begin
			if (!rst_n) begin
				cnt[i] <= '0;
			end else if (preset[i]) begin
				cnt[i].value <= preset_val;
				cnt[i].inc <= 1'b0;
			end else begin
				cnt[i].value <= cnt[i].value + {31'h0, bump[i]};
				cnt[i].inc <= bump[i];
			end
		end
	end
endmodule

// ==== sim/test_bus_perf_monitor_compare.sv ====
/*
 * Self-checking bench of the compare block: register table rows, then hand-written cases.
 * Assumes the counter model in bpmc_bus_model and a 40 MHz clock.
 */
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module test_bus_perf_monitor_compare;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic [1:0] rsp;} bpmc_row_t;

	logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, range_match, irq;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, pval, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs, bump, preset, qual_match, perf_status_collector, event_output_pins;
	bpmc_pkg::bpmc_cnt_t cnt [2];
	logic [38:7] addr;
	logic [2:0] qual [2];
	logic [1:0] grp [2];
	logic x;
	int num_errors, cmp_count;
	bpmc_row_t rows [7] = '{
		'{1'b0, bpmc_pkg::OFF_CMP0, 32'h0, 32'hffffffff, bpmc_pkg::RESP_OKAY},
		'{1'b0, bpmc_pkg::OFF_CMP1, 32'h0, 32'hffffffff, bpmc_pkg::RESP_OKAY},
		'{1'b0, bpmc_pkg::OFF_RESP0, 32'h0, 32'h0, bpmc_pkg::RESP_OKAY},
		'{1'b1, bpmc_pkg::OFF_CMP0, 32'h12345678, 32'h12345678, bpmc_pkg::RESP_OKAY},
		'{1'b1, bpmc_pkg::OFF_RESP0, 32'hffffffff, 32'h03c0c000, bpmc_pkg::RESP_OKAY},
		'{1'b1, bpmc_pkg::OFF_RESP1, 32'hfc000000, 32'h0, bpmc_pkg::RESP_OKAY},
		'{1'b1, 8'h10, 32'h1, 32'h0, bpmc_pkg::RESP_SLVERR}};

	bpmc_top DUT (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .event_counter(cnt),
		.bus_req_addr(addr), .event_qualifier_hit(qual), .event_group(grp), .qual_match(qual_match),
		.range_match(range_match), .perf_status_collector(perf_status_collector),
		.event_output_pins(event_output_pins), .irq(irq));

	bpmc_bus_model u_model (.clk(clk), .rst_n(rst_n), .bump(bump), .preset(preset), .preset_val(pval), .cnt(cnt));

	// ------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------
	// Each valid is held until its own ready is seen at an edge.
	// Local flags track what is still offered, since the valid signals update only after the edge.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		logic aw_p, w_p;
		n = 0;
		aw_p = 1'b1;
		w_p = 1'b1;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while ((aw_p || w_p) && n < 50) begin
			@(posedge clk);
			n++;
			if (aw_p && awready) begin
				aw_p = 1'b0;
				awvalid <= 1'b0;
			end
			if (w_p && wready) begin
				w_p = 1'b0;
				wvalid <= 1'b0;
			end
		end
		while (!bvalid && n < 100) begin
			@(posedge clk);
			n++;
		end
		if (!bvalid) num_errors++;
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (!arready && n < 50);
		arvalid <= 1'b0;
		while (!rvalid && n < 100) begin
			@(posedge clk);
			n++;
		end
		if (!rvalid) num_errors++;
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axi_wr(a, d, rs);
		`CHK(rs, bpmc_pkg::RESP_OKAY)
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		axi_rd(a, rd, rs);
		`CHK(rd, e)
	endtask

	// ------------------------------------------------------------
	// Counter side tasks
	// ------------------------------------------------------------
	// Outputs are sampled three edges after a request: model edge, block edge, then settled.
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask

	task automatic load_cnt(input logic [31:0] v);
		@(posedge clk);
		preset <= 2'b01;
		pval <= v;
		@(posedge clk);
		preset <= 2'b00;
		settle();
	endtask

	// One increment of counter 0; the report pulse must last exactly one cycle.
	task automatic bump_chk(input logic e);
		@(posedge clk);
		bump <= 2'b01;
		@(posedge clk);
		bump <= 2'b00;
		@(posedge clk);
		#1;
		`CHK({perf_status_collector[0], event_output_pins[0]}, {e, e})
		@(posedge clk);
		#1;
		`CHK(perf_status_collector[0], 1'b0)
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Clock, watchdog and sequence
	// ------------------------------------------------------------
	// Free-running 40 MHz clock.
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// The tests need a few hundred cycles, so a hang is cut off well above that.
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		complete_run();
	end

	initial begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready, bump, preset} = '0;
		{awaddr, araddr, wdata, wstrb, pval, addr} = '0;
		qual = '{3'h0, 3'h0};
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				axi_wr(rows[i].a, rows[i].d, rs);
				`CHK(rs, rows[i].rsp)
			end
			axi_rd(rows[i].a, rd, rs);
			`CHK({rd, rs}, {rows[i].x, rows[i].rsp})
		end
		$display("test register table done");
		// Compare value keeps bit 31 at zero in the max modes.
		wr(bpmc_pkg::OFF_IRQ_MASK, 32'h1);
		wr(bpmc_pkg::OFF_RESP0, 32'h0000c000);
		wr(bpmc_pkg::OFF_CMP0, 32'h64);
		load_cnt(32'h200);
		bump_chk(1'b0);
		rd_chk(bpmc_pkg::OFF_RESP0, 32'h0000c000);
		$display("test compare disabled done");
		wr(bpmc_pkg::OFF_RESP0, 32'h0040c000);
		load_cnt(32'h63);
		bump_chk(1'b0);
		bump_chk(1'b1);
		rd_chk(bpmc_pkg::OFF_RESP0, 32'h0040e000);
		`CHK(irq, 1'b1)
		rd_chk(bpmc_pkg::OFF_IRQ_ST, 32'h1);
		rd_chk(bpmc_pkg::OFF_IRQ_ST, 32'h0);
		`CHK(irq, 1'b0)
		wr(bpmc_pkg::OFF_RESP0, 32'h0040e000);
		rd_chk(bpmc_pkg::OFF_RESP0, 32'h0040c000);
		$display("test max compare done");
		load_cnt(32'h80000000);
		bump_chk(1'b0);
		rd_chk(bpmc_pkg::OFF_RESP0, 32'h0040d000);
		`CHK(irq, 1'b0)
		rd_chk(bpmc_pkg::OFF_IRQ_ST, 32'h4);
		$display("test overflow done");
		wr(bpmc_pkg::OFF_RESP0, 32'h00801000);
		wr(bpmc_pkg::OFF_CMP0, 32'h32);
		load_cnt(32'h4f);
		bump_chk(1'b0);
		bump_chk(1'b0);
		rd_chk(bpmc_pkg::OFF_CMP0, 32'h51);
		$display("test tracking done");
		wr(bpmc_pkg::OFF_CMP0, 32'h100);
		wr(bpmc_pkg::OFF_CMP1, 32'h200);
		wr(bpmc_pkg::OFF_RESP0, 32'h00c00000);
		wr(bpmc_pkg::OFF_RESP1, 32'h00c00000);
		qual <= '{3'h1, 3'h1};
		foreach (rows[i]) begin
			@(posedge clk);
			addr <= 32'hfe + 32'h40 * i;
			settle();
			x = (addr > 32'h100) && (addr <= 32'h200);
			`CHK({range_match, qual_match}, {x, x, x})
		end
		@(posedge clk);
		addr <= 32'h101;
		qual <= '{3'h6, 3'h1};
		settle();
		`CHK(qual_match, 2'b10)
		load_cnt(32'h1000);
		bump_chk(1'b0);
		rd_chk(bpmc_pkg::OFF_RESP0, 32'h00c00000);
		$display("test address range done");
		for (int g = 0; g < 4; g++) begin
			wr(bpmc_pkg::OFF_RESP1, 32'(g) << 24);
			qual[1] <= (g < 3) ? 3'(1 << g) : 3'h7;
			settle();
			`CHK({grp[1], qual_match[1]}, {2'(g), g < 3})
			qual[1] <= 3'h7 ^ 3'(1 << g);
			settle();
			`CHK(qual_match[1], 1'b0)
		end
		$display("test group selection done");
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rd_chk(bpmc_pkg::OFF_CMP0, 32'hffffffff);
		rd_chk(bpmc_pkg::OFF_RESP1, 32'h0);
		$display("test second reset done");
		complete_run();
	end
endmodule
